/* File: strap_config_regs.vh */
// Purpose: Constants for the reset strap configuration latch
// Assumes: Straps sampled on eight low data-bus inputs
// Notes:   Bit positions and encodings of the captured strap byte
`ifndef STRAP_CONFIG_REGS_VH
`define STRAP_CONFIG_REGS_VH

`define STRAP_WIDTH          8
`define STRAP_RESET_VALUE    8'h00
`define STRAP_ACK_BIT        7
`define STRAP_SIZE_HI        6
`define STRAP_SIZE_LO        5
`define STRAP_ADDR_CFG_BIT   4
`define STRAP_BYTE_LANE_BIT  3
`define STRAP_DIV_HI         2
`define STRAP_DIV_LO         0

`define SIZE_CODE_32BIT      2'h0
`define SIZE_CODE_8BIT       2'h1
`define PORT_WIDTH_32        2'h0
`define PORT_WIDTH_8         2'h1
`define PORT_WIDTH_16        2'h2

`define DIV_CODE_X3          3'h3
`define DIV_CODE_X4          3'h4
`define DIV_CODE_X5          3'h5
`define DIV_CODE_X6          3'h6
`define MULT_X3              3'h3
`define MULT_X4              3'h4
`define MULT_X5              3'h5
`define MULT_X6              3'h6
`define MULT_NONE            3'h0

`define ACK_WAIT_STATES      4'hf
`define ACK_WAIT_NONE        4'h0

`define FLAG_RESET_VALUE     1'b0
`define CODE_RESET_VALUE     3'h0
`define PIN_INPUT_RESET      1'b1
`define RESERVED_RESET       1'b1
`define BOOT_ONLY_RESET      1'b1

`define REV_FIELD_HI         19
`define REV_FIELD_LO         16
`define WORD_RESET_VALUE     32'h00000000

`endif

/* File: reset_strap_config_latch.v */
// Purpose: Capture reset straps and present boot configuration and ID words
// Assumes: Straps are stable and synchronous to clk_i while reset is held
// Notes:   Identification words are parameters with arbitrary defaults
`timescale 1ns/1ps
`include "strap_config_regs.vh"

// Overview of operation
// - Sample the eight low data inputs on each edge while reset is held.
// - Low three captured bits, two to zero, form the clock ratio code; bits three up are not frequency.
// - Bit seven zero disables boot auto acknowledge; one enables with fifteen waits.
// - Bits six and five: 00 is 32-bit, 01 is 8-bit, 1x is 16-bit.
// - Bit four zero keeps parallel pins as inputs; one gives address and control functions.
// - Bit three zero strobes byte lanes on writes only; one on reads and writes.
// - Boot chip select alone is active until other selects become valid.
// - After reset release load CPU word into register zero, memory word into one.
// - CPU word carries the core revision number in its own field.
// - Ratio codes 011 to 110 give multipliers three to six; others reserved.
module reset_strap_config_latch #(
    parameter [31:0] CPU_ID_WORD = 32'h12340000, // Arbitrary value
    parameter [31:0] MEM_ID_WORD = 32'h56780000, // Arbitrary value
    parameter [3:0]  CORE_REV    = 4'h1          // Arbitrary value
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Strap inputs
    input  wire [7:0]  data_strap_i,
    // Other chip selects made valid by software
    input  wire        other_cs_valid_i,
    // Boot configuration
    output wire        auto_acknowledge_o,
    output wire [3:0]  auto_ack_wait_states_o,
    output reg  [1:0]  boot_port_size_o,
    output wire        parallel_port_as_address_o,
    output wire        parallel_port_as_input_o,
    output wire        byte_lane_mode_select_o,
    output wire        byte_lane_on_reads_o,
    output wire [2:0]  clock_ratio_code_o,
    output reg  [2:0]  clock_multiplier_o,
    output wire        clock_ratio_reserved_o,
    output wire        boot_cs_only_o,
    // Identification words
    output reg  [31:0] data_reg0_o,
    output reg  [31:0] data_reg1_o,
    output reg         id_loaded_o
);

    localparam STRAP_W = `STRAP_WIDTH;

    // Run state and strobes
    reg                run_reg;
    wire               sample_en;
    wire               load_en;

    // Sampled straps, one flop per pin
    wire [STRAP_W-1:0] strap_sample;

    // Decoded configuration, next values
    reg                ack_next;
    reg  [3:0]         wait_next;
    reg  [1:0]         size_next;
    reg                addr_cfg_next;
    reg                as_input_next;
    reg                byte_lane_next;
    reg  [2:0]         code_next;
    reg  [2:0]         mult_next;
    reg                reserved_next;

    // Decoded configuration, held values
    reg                ack_reg;
    reg  [3:0]         wait_reg;
    reg                addr_cfg_reg;
    reg                as_input_reg;
    reg                byte_lane_reg;
    reg  [2:0]         code_reg;
    reg                reserved_reg;

    // Chip-select hand-over
    reg                boot_only_reg;
    reg                boot_only_next;

    // Identification words, next values
    reg  [31:0]        word0_next;
    reg  [31:0]        word1_next;

    // Low while reset is held and through the first edge after release
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg <= `FLAG_RESET_VALUE;
        end else begin
            run_reg <= 1'b1;
        end
    end

    assign sample_en = ~run_reg & ~rst_n_i;
    assign load_en   = ~run_reg;

    // No reset on these flops, or the last sample would be lost at release
    genvar g;
    generate
        for (g = 0; g < STRAP_W; g = g + 1) begin : g_strap
            reg bit_reg;
            always @(posedge clk_i) begin
                if (sample_en) begin
                    bit_reg <= data_strap_i[g];
                end
            end
            assign strap_sample[g] = bit_reg;
        end
    endgenerate

    always @* begin
        ack_next       = strap_sample[`STRAP_ACK_BIT];
        addr_cfg_next  = strap_sample[`STRAP_ADDR_CFG_BIT];
        as_input_next  = ~strap_sample[`STRAP_ADDR_CFG_BIT];
        byte_lane_next = strap_sample[`STRAP_BYTE_LANE_BIT];
        code_next      = strap_sample[`STRAP_DIV_HI:`STRAP_DIV_LO];
    end

    // Wait states only mean anything with auto acknowledge on
    always @* begin
        if (ack_next) begin
            wait_next = `ACK_WAIT_STATES;
        end else begin
            wait_next = `ACK_WAIT_NONE;
        end
    end

    always @* begin
        case (strap_sample[`STRAP_SIZE_HI:`STRAP_SIZE_LO])
            `SIZE_CODE_32BIT: begin
                size_next = `PORT_WIDTH_32;
            end
            `SIZE_CODE_8BIT: begin
                size_next = `PORT_WIDTH_8;
            end
            default: begin
                size_next = `PORT_WIDTH_16;
            end
        endcase
    end

    always @* begin
        case (code_next)
            `DIV_CODE_X3: begin
                mult_next = `MULT_X3;
            end
            `DIV_CODE_X4: begin
                mult_next = `MULT_X4;
            end
            `DIV_CODE_X5: begin
                mult_next = `MULT_X5;
            end
            `DIV_CODE_X6: begin
                mult_next = `MULT_X6;
            end
            default: begin
                mult_next = `MULT_NONE;
            end
        endcase
    end

    // Zero multiplier doubles as the reserved marker for the clock logic
    always @* begin
        reserved_next = (mult_next == `MULT_NONE);
    end

    // Loaded once at the first edge after release, then frozen until reset
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg            <= `FLAG_RESET_VALUE;
            wait_reg           <= `ACK_WAIT_NONE;
            boot_port_size_o   <= `PORT_WIDTH_32;
            addr_cfg_reg       <= `FLAG_RESET_VALUE;
            as_input_reg       <= `PIN_INPUT_RESET;
            byte_lane_reg      <= `FLAG_RESET_VALUE;
            code_reg           <= `CODE_RESET_VALUE;
            clock_multiplier_o <= `MULT_NONE;
            reserved_reg       <= `RESERVED_RESET;
        end else if (load_en) begin
            ack_reg            <= ack_next;
            wait_reg           <= wait_next;
            boot_port_size_o   <= size_next;
            addr_cfg_reg       <= addr_cfg_next;
            as_input_reg       <= as_input_next;
            byte_lane_reg      <= byte_lane_next;
            code_reg           <= code_next;
            clock_multiplier_o <= mult_next;
            reserved_reg       <= reserved_next;
        end
    end

    assign auto_acknowledge_o         = ack_reg;
    assign auto_ack_wait_states_o     = wait_reg;
    assign parallel_port_as_address_o = addr_cfg_reg;
    assign parallel_port_as_input_o   = as_input_reg;
    assign byte_lane_mode_select_o    = byte_lane_reg;
    assign byte_lane_on_reads_o       = byte_lane_reg;
    assign clock_ratio_code_o         = code_reg;
    assign clock_ratio_reserved_o     = reserved_reg;

    // Sticky: once other selects are valid, only reset restores boot-only
    always @* begin
        boot_only_next = boot_only_reg & ~other_cs_valid_i;
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_only_reg <= `BOOT_ONLY_RESET;
        end else begin
            boot_only_reg <= boot_only_next;
        end
    end

    assign boot_cs_only_o = boot_only_reg;

    // Revision overlays the base word so one parameter tracks the core
    always @* begin
        word0_next                              = CPU_ID_WORD;
        word0_next[`REV_FIELD_HI:`REV_FIELD_LO] = CORE_REV;
        word1_next                              = MEM_ID_WORD;
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_reg0_o <= `WORD_RESET_VALUE;
            data_reg1_o <= `WORD_RESET_VALUE;
            id_loaded_o <= `FLAG_RESET_VALUE;
        end else if (load_en) begin
            data_reg0_o <= word0_next;
            data_reg1_o <= word1_next;
            id_loaded_o <= 1'b1;
        end
    end

endmodule // reset_strap_config_latch

/* File: strap_board.sv */
// Purpose: Board strap model on the low data lines
// Assumes: Bench sets the strap value
// Notes:   Released bus shows a changing pattern
`timescale 1ns/1ps
module strap_board (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] value_i,
    output wire logic [7:0] data_o
);
    logic [7:0] cnt_reg = 8'h00;
    always @(posedge clk_i) cnt_reg <= cnt_reg + 8'h01;
    // Equals the old strap only when cnt_reg is 8'hff once released, so stale captures show up
    assign data_o = rst_n_i ? ~value_i ^ cnt_reg : value_i;
endmodule // strap_board

/* File: reset_strap_config_latch_asserts.sv */
// Purpose: Port checker for the strap latch
// Assumes: Straps sampled on every edge in reset
// Notes:   Bound to every latch instance
`timescale 1ns/1ps
module reset_strap_config_latch_asserts #(parameter [3:0] CORE_REV = 4'h1) (
    input wire logic clk_i, rst_n_i, other_cs_valid_i, auto_acknowledge_o, id_loaded_o,
    input wire logic parallel_port_as_address_o, parallel_port_as_input_o, boot_cs_only_o,
    input wire logic byte_lane_mode_select_o, byte_lane_on_reads_o, clock_ratio_reserved_o,
    input wire logic [7:0] data_strap_i,
    input wire logic [3:0] auto_ack_wait_states_o,
    input wire logic [1:0] boot_port_size_o,
    input wire logic [2:0] clock_ratio_code_o, clock_multiplier_o,
    input wire logic [31:0] data_reg0_o, data_reg1_o
);
    logic [7:0] cap_reg;
    always @(posedge clk_i) if (!rst_n_i) cap_reg <= data_strap_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_wait_states: assert property (auto_ack_wait_states_o == {4{auto_acknowledge_o}})
        else $error("wait states wrong");
    chk_ratio_decode: assert property (clock_multiplier_o == ((clock_ratio_code_o >= 3'h3 &&
        clock_ratio_code_o <= 3'h6) ? clock_ratio_code_o : 3'h0)
        && clock_ratio_reserved_o == (clock_multiplier_o == 3'h0)) else $error("ratio decode wrong");
    chk_strap_bits: assert property (id_loaded_o |-> {auto_acknowledge_o,
        parallel_port_as_address_o, byte_lane_mode_select_o, clock_ratio_code_o} == {cap_reg[7],
        cap_reg[4:0]}) else $error("captured straps wrong");
    chk_port_size: assert property (id_loaded_o |->
        boot_port_size_o == (cap_reg[6] ? 2'h2 : {1'b0, cap_reg[5]})) else $error("port size wrong");
    chk_load_after: assert property (!$past(rst_n_i) |=> id_loaded_o &&
        data_reg0_o[19:16] == CORE_REV) else $error("words not loaded");
    chk_words_hold: assert property (id_loaded_o |=> id_loaded_o && $stable(data_reg0_o)
        && $stable(data_reg1_o)) else $error("words changed");
    chk_cs_release: assert property (other_cs_valid_i |=> !boot_cs_only_o)
        else $error("boot select still sole");
    chk_cs_keep: assert property ($fell(boot_cs_only_o) |-> $past(other_cs_valid_i))
        else $error("boot select dropped early");
    cover property (id_loaded_o && auto_acknowledge_o);
    cover property (id_loaded_o && clock_ratio_reserved_o);
    cover property ($fell(boot_cs_only_o));
endmodule // reset_strap_config_latch_asserts
bind reset_strap_config_latch reset_strap_config_latch_asserts #(.CORE_REV(CORE_REV)) chk (.*);

/* File: reset_strap_config_latch_bench.sv */
// Purpose: Self-checking bench for the strap latch
// Assumes: Straps held two edges before each release
// Notes:   Strap rows first, then chip-select hand-over
`timescale 1ns/1ps
module reset_strap_config_latch_bench;
    logic clk_i, rst_n_i, other_cs_valid_i, auto_acknowledge_o, id_loaded_o, boot_cs_only_o;
    logic parallel_port_as_address_o, parallel_port_as_input_o, clock_ratio_reserved_o;
    logic byte_lane_mode_select_o, byte_lane_on_reads_o;
    logic [7:0] strap, data_strap_i;
    logic [3:0] auto_ack_wait_states_o;
    logic [1:0] boot_port_size_o;
    logic [2:0] clock_ratio_code_o, clock_multiplier_o;
    logic [31:0] data_reg0_o, data_reg1_o;
    int mismatches = 0, checks_done = 0;
    // Strap, wait states, port size, multiplier, reserved
    logic [17:0] rows [8] = '{{8'h00, 4'h0, 2'h0, 3'h0, 1'b1}, {8'h23, 4'h0, 2'h1, 3'h3, 1'b0},
        {8'hc4, 4'hf, 2'h2, 3'h4, 1'b0}, {8'hf5, 4'hf, 2'h2, 3'h5, 1'b0},
        {8'h1e, 4'h0, 2'h0, 3'h6, 1'b0}, {8'h8f, 4'hf, 2'h0, 3'h0, 1'b1},
        {8'h69, 4'h0, 2'h2, 3'h0, 1'b1}, {8'h52, 4'h0, 2'h2, 3'h0, 1'b1}};
    strap_board board (.clk_i(clk_i), .rst_n_i(rst_n_i), .value_i(strap), .data_o(data_strap_i));
    reset_strap_config_latch #(.CPU_ID_WORD(32'h0a0b0c0d), .MEM_ID_WORD(32'h01020304),
        .CORE_REV(4'h2)) DUT (.*); // Arbitrary identity values
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task restrap(input logic [7:0] s);
        int n;
        rst_n_i = 1'b0;
        strap = s;
        repeat (2) @(posedge clk_i);
        #1 check({id_loaded_o, boot_cs_only_o}, 2'b01);
        rst_n_i = 1'b1;
        for (n = 0; n < 4 && id_loaded_o !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n == 4) begin
            mismatches++;
            conclude;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        rst_n_i = 1'b0;
        other_cs_valid_i = 1'b0;
        strap = 8'h00;
        repeat (8) @(posedge clk_i);
        #1;
        foreach (rows[i]) begin
            restrap(rows[i][17:10]);
            @(posedge clk_i);
            #1 check({auto_ack_wait_states_o, boot_port_size_o, clock_multiplier_o,
                clock_ratio_reserved_o}, rows[i][9:0]);
            check({auto_acknowledge_o, parallel_port_as_address_o, byte_lane_mode_select_o,
                clock_ratio_code_o, parallel_port_as_input_o, byte_lane_on_reads_o},
                {rows[i][17], rows[i][14:10], ~rows[i][14], rows[i][13]});
            check(data_reg0_o, 32'h0a020c0d);
            check(data_reg1_o, 32'h01020304);
        end
        other_cs_valid_i = 1'b1;
        @(posedge clk_i);
        #1 other_cs_valid_i = 1'b0;
        check(boot_cs_only_o, 1'b0);
        repeat (2) @(posedge clk_i);
        #1 check(boot_cs_only_o, 1'b0);
        restrap(8'h23);
        check(boot_cs_only_o, 1'b1);
        conclude;
    end
endmodule // reset_strap_config_latch_bench
